// ---- nts_bridge_pkg.sv ----
// constants shared by both ends of the narrow timestamp bridge link
// assumes a single system clock with per-side clock enables
`default_nettype none
package nts_bridge_pkg;
  localparam int TS_W = 7;
  localparam int SYNC_W = 2;
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_RESYNC_BIT = 7;
  localparam logic [6:0] TS_IDLE = 7'h00;
  localparam logic [6:0] TS_RESYNC = 7'h7f;
  localparam logic [6:0] ACC_MAX = 7'h7e;
  localparam logic [7:0] SUM_LIMIT = 8'h7e;
  localparam logic [7:0] WORD_RESYNC = 8'h80;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [6:0] ACC_RST = 7'h00;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] DIV_ONE = 4'h1;
  localparam logic [31:0] CNT_RST = 32'h0;

  typedef enum logic [3:0] {
    P_RUN = 4'b0001,
    P_DRAIN = 4'b0010,
    P_DOWN = 4'b0100,
    P_WAKE = 4'b1000
  } pwr_state_e;
endpackage
`default_nettype wire

// ---- nts_link_if.sv ----
// link between the bridge and its upstream/downstream/controller partner
// assumes both ends share sys_clk; no clocking block
`default_nettype none
interface nts_link_if;
  import nts_bridge_pkg::*;
  logic s_ce;
  logic m_ce;
  logic [TS_W-1:0] s_ts;
  logic [SYNC_W-1:0] s_sync;
  logic s_sync_valid;
  logic s_sync_ready;
  logic [TS_W-1:0] m_ts;
  logic m_ts_valid;
  logic [SYNC_W-1:0] m_sync;
  logic m_sync_valid;
  logic m_sync_ready;
  logic pwr_qreq_n;
  logic pwr_qaccept_n;
  logic clk_qreq_n;
  logic clk_qaccept_n;
  logic clk_qactive;

  modport bridge (
    input s_ce, m_ce, s_ts, s_sync, s_sync_valid, m_sync_ready, pwr_qreq_n, clk_qreq_n,
    output s_sync_ready, m_ts, m_ts_valid, m_sync, m_sync_valid, pwr_qaccept_n, clk_qaccept_n, clk_qactive
  );
  modport partner (
    output s_ce, m_ce, s_ts, s_sync, s_sync_valid, m_sync_ready, pwr_qreq_n, clk_qreq_n,
    input s_sync_ready, m_ts, m_ts_valid, m_sync, m_sync_valid, pwr_qaccept_n, clk_qaccept_n, clk_qactive
  );
endinterface
`default_nettype wire

// ---- nts_word_fifo.sv ----
// flip-flop fifo with valid/ready on both sides
// assumes one clock; full and empty come from an occupancy count
`default_nettype none
module nts_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // honest flags straight from the count
  always_comb begin
    in_ready_out = (cnt_ff != FULL_CNT);
    out_valid_out = (cnt_ff != '0);
    out_data_out = mem_ff[rd_ff];
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    nxt_wr = push ? ((wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd = pop ? ((rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage entries, one per index; data needs no reset
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge sys_clk_in) begin
      if (push && (wr_ff == AW'(i))) begin
        mem_ff[i] <= in_data_in;
      end
    end
  end
endmodule
`default_nettype wire

// ---- nts_sync_bridge.sv ----
// narrow timestamp synchronous bridge: slave side in, master side out
// assumes s_ce and m_ce derive from sys_clk_in, one power domain inside
`default_nettype none
module nts_sync_bridge (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // link to partner
  nts_link_if.bridge link
);
  import nts_bridge_pkg::*;

  pwr_state_e pwr_ff, nxt_pwr;
  logic [TS_W-1:0] acc_ff, nxt_acc;
  logic pend_ff, nxt_pend;
  logic gated_ff, nxt_gated;
  logic pacc_n_ff, nxt_pacc_n;
  logic cacc_n_ff, nxt_cacc_n;
  logic qact_ff, nxt_qact;
  logic [TS_W-1:0] mts_ff, nxt_mts;
  logic mvld_ff, nxt_mvld;
  logic [SYNC_W-1:0] msync_ff, nxt_msync;
  logic msvld_ff, nxt_msvld;
  logic srdy_ff, nxt_srdy;
  logic fin_valid, fin_ready, fout_valid, fout_ready;
  logic [WORD_W-1:0] fin_data, fout_data;
  logic [7:0] sum;
  logic s_take, pwr_change;

  // timestamp words sit here between slave and master side
  nts_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) nts_word_fifo_inst (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .in_valid_in(fin_valid),
    .in_ready_out(fin_ready),
    .in_data_in(fin_data),
    .out_valid_out(fout_valid),
    .out_ready_in(fout_ready),
    .out_data_out(fout_data)
  );

  // slave side and power channel; all slave work waits on s_ce
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_acc = acc_ff;
    nxt_pend = pend_ff;
    nxt_pacc_n = pacc_n_ff;
    fin_valid = 1'b0;
    fin_data = WORD_RESYNC;
    sum = {1'b0, acc_ff} + {1'b0, link.s_ts};
    s_take = link.s_ce && !gated_ff;
    case (pwr_ff)
      P_RUN: begin
        // a gated bridge stands still; the request is taken once the clock is back
        if (!link.pwr_qreq_n && !gated_ff) begin
          nxt_pwr = P_DRAIN;
          // steps not yet queued are dropped here; the resync on wake covers them
          nxt_acc = ACC_RST;
          nxt_pend = 1'b0;
        end else if (s_take) begin
          if (pend_ff) begin
            fin_valid = 1'b1;
            nxt_pend = !fin_ready;
          end else if (sum > SUM_LIMIT) begin
            // too far behind: give up on steps and force a resync instead
            nxt_pend = 1'b1;
            nxt_acc = ACC_RST;
          end else if (sum != 8'h00) begin
            fin_valid = 1'b1;
            fin_data = {1'b0, sum[6:0]};
            nxt_acc = fin_ready ? ACC_RST : sum[6:0];
          end
        end
      end
      P_DRAIN: begin
        // fifo keeps draining through the master side; accept once empty
        if (!fout_valid && !gated_ff) begin
          nxt_pwr = P_DOWN;
          nxt_pacc_n = 1'b0;
        end
      end
      P_DOWN: begin
        if (link.pwr_qreq_n && !gated_ff) begin
          nxt_pwr = P_WAKE;
          nxt_pacc_n = 1'b1;
          nxt_acc = ACC_RST;
        end
      end
      P_WAKE: begin
        // incoming steps are dropped until the resync word is queued
        if (s_take) begin
          fin_valid = 1'b1;
          if (fin_ready) begin
            nxt_pwr = P_RUN;
          end
        end
      end
      default: begin
        nxt_pwr = P_RUN;
        nxt_pacc_n = 1'b1;
      end
    endcase
  end

  // clock channel; gating only while no power change is pending
  always_comb begin
    pwr_change = (link.pwr_qreq_n != pacc_n_ff);
    nxt_gated = gated_ff;
    if (gated_ff) begin
      nxt_gated = !link.clk_qreq_n;
    end else if (!link.clk_qreq_n && !pwr_change && (pwr_ff == P_RUN || pwr_ff == P_DOWN)) begin
      nxt_gated = 1'b1;
    end
    nxt_cacc_n = !nxt_gated;
    // clock activity asks for the clock back only while a power change waits
    nxt_qact = nxt_gated && pwr_change;
  end

  // master side: one word per master enable, resync word maps to its code
  always_comb begin
    fout_ready = link.m_ce && !gated_ff;
    // a popped word shows for exactly one cycle; m_ts itself holds
    nxt_mvld = fout_valid && fout_ready;
    nxt_mts = mts_ff;
    if (nxt_mvld) begin
      nxt_mts = fout_data[WORD_RESYNC_BIT] ? TS_RESYNC : fout_data[TS_W-1:0];
    end
  end

  // sync channel: one-deep stage, discards everything while powered down
  always_comb begin
    nxt_msync = msync_ff;
    nxt_msvld = msvld_ff;
    if (link.m_ce && !gated_ff && link.m_sync_ready) begin
      nxt_msvld = 1'b0;
    end
    if (link.s_ce && !gated_ff && link.s_sync_valid && srdy_ff && pwr_ff == P_RUN) begin
      nxt_msync = link.s_sync;
      nxt_msvld = 1'b1;
    end
    // ready is forced high outside run so the upstream clock may stop
    nxt_srdy = (nxt_pwr != P_RUN) || !nxt_msvld;
  end

  // registers only; every next value is formed above
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_ff <= P_RUN;
      acc_ff <= ACC_RST;
      pend_ff <= 1'b1;
      gated_ff <= 1'b0;
      pacc_n_ff <= 1'b1;
      cacc_n_ff <= 1'b1;
      qact_ff <= 1'b0;
      mts_ff <= TS_IDLE;
      mvld_ff <= 1'b0;
      msync_ff <= SYNC_RST;
      msvld_ff <= 1'b0;
      srdy_ff <= 1'b1;
    end else begin
      pwr_ff <= nxt_pwr;
      acc_ff <= nxt_acc;
      pend_ff <= nxt_pend;
      gated_ff <= nxt_gated;
      pacc_n_ff <= nxt_pacc_n;
      cacc_n_ff <= nxt_cacc_n;
      qact_ff <= nxt_qact;
      mts_ff <= nxt_mts;
      mvld_ff <= nxt_mvld;
      msync_ff <= nxt_msync;
      msvld_ff <= nxt_msvld;
      srdy_ff <= nxt_srdy;
    end
  end

  // all link outputs come straight from flops
  assign link.m_ts = mts_ff;
  assign link.m_ts_valid = mvld_ff;
  assign link.m_sync = msync_ff;
  assign link.m_sync_valid = msvld_ff;
  assign link.s_sync_ready = srdy_ff;
  assign link.pwr_qaccept_n = pacc_n_ff;
  assign link.clk_qaccept_n = cacc_n_ff;
  assign link.clk_qactive = qact_ff;
endmodule
`default_nettype wire

// ---- nts_link_partner.sv ----
// partner end: enables, upstream encoder feed, downstream capture, controllers
// assumes user-side requests are synchronous to sys_clk_in
`default_nettype none
module nts_link_partner (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // enable ratios, divide by value+1
  input wire logic [3:0] s_div_in,
  input wire logic [3:0] m_div_in,
  // upstream feed
  input wire logic [nts_bridge_pkg::TS_W-1:0] ts_step_in,
  input wire logic [nts_bridge_pkg::SYNC_W-1:0] sync_sym_in,
  input wire logic sync_sym_valid_in,
  // controller requests
  input wire logic pwr_down_req_in,
  input wire logic clk_gate_req_in,
  // downstream results
  output logic [31:0] time_count_out,
  output logic resync_seen_out,
  output logic [nts_bridge_pkg::SYNC_W-1:0] sync_sym_out,
  output logic sync_sym_valid_out,
  output logic pwr_off_ok_out,
  output logic clk_gated_out,
  output logic clk_wake_out,
  // link to bridge
  nts_link_if.partner link
);
  import nts_bridge_pkg::*;

  logic [3:0] sdiv_ff, nxt_sdiv, mdiv_ff, nxt_mdiv;
  logic sce_ff, nxt_sce, mce_ff, nxt_mce;
  logic [TS_W-1:0] step_ff, nxt_step;
  logic [SYNC_W-1:0] ssym_ff, nxt_ssym;
  logic ssv_ff, nxt_ssv;
  logic [31:0] cnt_ff, nxt_cnt;
  logic rs_ff, nxt_rs;
  logic [SYNC_W-1:0] osym_ff, nxt_osym;
  logic osv_ff, nxt_osv;
  logic pq_ff, nxt_pq, cq_ff, nxt_cq;
  logic ok_ff, nxt_ok, cg_ff, nxt_cg, wk_ff, nxt_wk;
  logic drain_hold;

  // both enables come from dividers on the one clock; m_ce also runs every cycle while a power request waits for its accept
  always_comb begin
    drain_hold = !pq_ff && link.pwr_qaccept_n;
    nxt_sdiv = (sdiv_ff >= s_div_in) ? DIV_RST : sdiv_ff + DIV_ONE;
    nxt_mdiv = (mdiv_ff >= m_div_in) ? DIV_RST : mdiv_ff + DIV_ONE;
    nxt_sce = (sdiv_ff >= s_div_in);
    nxt_mce = (mdiv_ff >= m_div_in) || drain_hold;
  end

  // upstream feed: one step per slave enable, sync symbol held until taken
  always_comb begin
    nxt_step = sce_ff ? TS_IDLE : step_ff;
    if (nxt_sce) begin
      nxt_step = ts_step_in;
    end
    nxt_ssym = ssym_ff;
    nxt_ssv = ssv_ff;
    if (sce_ff && ssv_ff && link.s_sync_ready) begin
      nxt_ssv = 1'b0;
    end
    if (!nxt_ssv && sync_sym_valid_in) begin
      nxt_ssym = sync_sym_in;
      nxt_ssv = 1'b1;
    end
  end

  // downstream decoder: accumulate steps, flag resync words
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_rs = 1'b0;
    if (link.m_ts_valid) begin
      if (link.m_ts == TS_RESYNC) begin
        nxt_rs = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + {25'h0, link.m_ts};
      end
    end
    nxt_osv = mce_ff && link.m_sync_valid;
    nxt_osym = nxt_osv ? link.m_sync : osym_ff;
  end

  // controllers: request, then wait for the bridge's accept
  always_comb begin
    nxt_pq = !pwr_down_req_in;
    nxt_ok = !pq_ff && !link.pwr_qaccept_n;
    nxt_cq = !clk_gate_req_in;
    nxt_cg = !cq_ff && !link.clk_qaccept_n;
    nxt_wk = link.clk_qactive;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sdiv_ff <= DIV_RST;
      mdiv_ff <= DIV_RST;
      sce_ff <= 1'b0;
      mce_ff <= 1'b0;
      step_ff <= TS_IDLE;
      ssym_ff <= SYNC_RST;
      ssv_ff <= 1'b0;
      cnt_ff <= CNT_RST;
      rs_ff <= 1'b0;
      osym_ff <= SYNC_RST;
      osv_ff <= 1'b0;
      pq_ff <= 1'b1;
      cq_ff <= 1'b1;
      ok_ff <= 1'b0;
      cg_ff <= 1'b0;
      wk_ff <= 1'b0;
    end else begin
      sdiv_ff <= nxt_sdiv;
      mdiv_ff <= nxt_mdiv;
      sce_ff <= nxt_sce;
      mce_ff <= nxt_mce;
      step_ff <= nxt_step;
      ssym_ff <= nxt_ssym;
      ssv_ff <= nxt_ssv;
      cnt_ff <= nxt_cnt;
      rs_ff <= nxt_rs;
      osym_ff <= nxt_osym;
      osv_ff <= nxt_osv;
      pq_ff <= nxt_pq;
      cq_ff <= nxt_cq;
      ok_ff <= nxt_ok;
      cg_ff <= nxt_cg;
      wk_ff <= nxt_wk;
    end
  end

  assign link.s_ce = sce_ff;
  assign link.m_ce = mce_ff;
  assign link.s_ts = step_ff;
  assign link.s_sync = ssym_ff;
  assign link.s_sync_valid = ssv_ff;
  assign link.m_sync_ready = 1'b1;
  assign link.pwr_qreq_n = pq_ff;
  assign link.clk_qreq_n = cq_ff;
  assign time_count_out = cnt_ff;
  assign resync_seen_out = rs_ff;
  assign sync_sym_out = osym_ff;
  assign sync_sym_valid_out = osv_ff;
  assign pwr_off_ok_out = ok_ff;
  assign clk_gated_out = cg_ff;
  assign clk_wake_out = wk_ff;
endmodule
`default_nettype wire

// ---- nts_link_monitor.sv ----
// checker watching the link between bridge and partner ends
// assumes one clock; instantiated beside the link interface
`default_nettype none
module nts_link_monitor (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // master side stream
  input wire logic [nts_bridge_pkg::TS_W-1:0] m_ts,
  input wire logic m_ts_valid,
  input wire logic [nts_bridge_pkg::SYNC_W-1:0] m_sync,
  input wire logic m_sync_valid,
  input wire logic m_ce,
  input wire logic m_sync_ready,
  input wire logic s_sync_ready,
  // q-channels
  input wire logic pwr_qreq_n,
  input wire logic pwr_qaccept_n,
  input wire logic clk_qreq_n,
  input wire logic clk_qaccept_n,
  input wire logic clk_qactive
);
  import nts_bridge_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // resync code leaving the master side
  sequence resync_word;
    m_ts_valid && m_ts == TS_RESYNC;
  endsequence
  // power handshake just released
  sequence pwr_up_seen;
    !pwr_qaccept_n ##1 pwr_qaccept_n;
  endsequence
  a_ready_while_down: assert property (!pwr_qaccept_n |-> s_sync_ready)
    else $error("sync ready low while power quiesced");
  a_accept_needs_req: assert property ($fell(pwr_qaccept_n) |-> !pwr_qreq_n)
    else $error("power accept without request");
  // drain is bounded by a full fifo at the slowest master enable
  a_never_denied: assert property (!pwr_qreq_n && clk_qreq_n && clk_qaccept_n |-> ##[0:600] !pwr_qaccept_n)
    else $error("power request not accepted");
  a_accept_release: assert property (pwr_qreq_n && !pwr_qaccept_n && clk_qaccept_n |=> pwr_qaccept_n)
    else $error("power accept held after release");
  a_clk_accept: assert property (!clk_qreq_n && clk_qaccept_n && pwr_qreq_n == pwr_qaccept_n
    |-> ##[1:40] !clk_qaccept_n)
    else $error("clock request not accepted");
  a_clk_release: assert property (clk_qreq_n && !clk_qaccept_n |=> clk_qaccept_n)
    else $error("clock accept held after release");
  a_wake_gated: assert property (!clk_qaccept_n && !clk_qreq_n && pwr_qreq_n != pwr_qaccept_n
    |=> clk_qactive)
    else $error("no clock activity on power change");
  a_resync_after_up: assert property (pwr_up_seen |-> ##[0:60] resync_word)
    else $error("no resync word after power up");
  a_step_nonzero: assert property (m_ts_valid |-> m_ts != TS_IDLE)
    else $error("empty step word sent");
  a_sync_held: assert property (m_sync_valid && !(m_ce && m_sync_ready) && pwr_qreq_n
    |=> m_sync_valid && $stable(m_sync))
    else $error("sync symbol dropped before taken");
endmodule
`default_nettype wire

// ---- narrow_timestamp_sync_bridge_bench.sv ----
// bench joining bridge and partner ends over one link
// assumes partner user side drives the enables and controllers
`default_nettype none
module narrow_timestamp_sync_bridge_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import nts_bridge_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] s_div = 4'h0;
  logic [3:0] m_div = 4'h0;
  logic [TS_W-1:0] ts_step = 7'h00;
  logic [SYNC_W-1:0] sym = 2'h0;
  logic sym_valid = 1'b0;
  logic pwr_req = 1'b0;
  logic clk_req = 1'b0;
  logic [31:0] time_count;
  logic [SYNC_W-1:0] sym_out;
  logic resync_seen, sym_valid_out, off_ok, gated, wake;
  logic [31:0] sent = 32'h0;
  int words = 0;
  int resyncs = 0;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  nts_link_if link ();
  // 50 MHz clock
  always #10 sys_clk_in = ~sys_clk_in;
  nts_sync_bridge nts_sync_bridge_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(link.bridge));
  nts_link_partner nts_link_partner_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .s_div_in(s_div),
    .m_div_in(m_div), .ts_step_in(ts_step), .sync_sym_in(sym), .sync_sym_valid_in(sym_valid),
    .pwr_down_req_in(pwr_req), .clk_gate_req_in(clk_req), .time_count_out(time_count),
    .resync_seen_out(resync_seen), .sync_sym_out(sym_out), .sync_sym_valid_out(sym_valid_out),
    .pwr_off_ok_out(off_ok), .clk_gated_out(gated), .clk_wake_out(wake), .link(link.partner));
  nts_link_monitor nts_link_monitor_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .m_ts(link.m_ts),
    .m_ts_valid(link.m_ts_valid), .m_sync(link.m_sync), .m_sync_valid(link.m_sync_valid), .m_ce(link.m_ce),
    .m_sync_ready(link.m_sync_ready), .s_sync_ready(link.s_sync_ready), .pwr_qreq_n(link.pwr_qreq_n),
    .pwr_qaccept_n(link.pwr_qaccept_n), .clk_qreq_n(link.clk_qreq_n), .clk_qaccept_n(link.clk_qaccept_n),
    .clk_qactive(link.clk_qactive));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // tally steps offered and step words delivered; the ceiling cuts a hang short
  always @(posedge sys_clk_in) begin
    cycles++;
    if (link.s_ce) sent <= sent + 32'(link.s_ts);
    if (link.m_ts_valid && link.m_ts != TS_RESYNC) words++;
    if (link.m_ts_valid && link.m_ts == TS_RESYNC) resyncs++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // bounded wait on a partner flag, then judge its level
  task automatic wait_for(ref logic f, input logic lvl, input int lim);
    for (int n = 0; n < lim && f !== lvl; n++) @(negedge sys_clk_in);
    check({31'h0, f}, {31'h0, lvl});
  endtask
  // steady stream at a given ratio; the sum must survive any merging
  task automatic t_steps(input logic [6:0] step, input logic [3:0] sd, input logic [3:0] md, input int n);
    logic [31:0] tb;
    logic [31:0] sb;
    int wb;
    s_div = sd;
    m_div = md;
    settle(2);
    tb = time_count;
    sb = sent;
    wb = words;
    ts_step = step;
    settle(n);
    ts_step = 7'h00;
    settle(400);
    check(time_count - tb, sent - sb);
    if (md > sd) check({31'h0, (words - wb) < int'((sent - sb) / step)}, 32'h1);
  endtask
  // large steps into a slow master overflow the accumulator: time is lost, a resync goes out
  task automatic t_overflow();
    logic [31:0] tb;
    logic [31:0] sb;
    int rb;
    s_div = 4'h0;
    m_div = 4'hf;
    settle(2);
    tb = time_count;
    sb = sent;
    rb = resyncs;
    ts_step = 7'h7e;
    settle(40);
    ts_step = 7'h00;
    settle(400);
    check({31'h0, (resyncs - rb) > 0}, 32'h1);
    check({31'h0, (time_count - tb) < (sent - sb)}, 32'h1);
  endtask
  // every sync symbol crosses intact
  task automatic t_sync();
    s_div = 4'h0;
    m_div = 4'h0;
    for (int s = 0; s < 4; s++) begin
      sym = 2'(s);
      sym_valid = 1'b1;
      settle(1);
      sym_valid = 1'b0;
      wait_for(sym_valid_out, 1'b1, 40);
      check({30'h0, sym_out}, s);
      settle(4);
    end
  endtask
  // power down with words in flight, ignore traffic while down, power up
  task automatic t_power();
    logic [31:0] tb;
    logic [31:0] sb;
    m_div = 4'h7;
    tb = time_count;
    sb = sent;
    ts_step = 7'h04;
    settle(30);
    ts_step = 7'h00;
    // let the accumulator reach the fifo before asking for power down
    settle(20);
    pwr_req = 1'b1;
    wait_for(off_ok, 1'b1, 600);
    check(time_count - tb, sent - sb);
    tb = time_count;
    sym_valid = 1'b1;
    ts_step = 7'h06;
    settle(10);
    check({31'h0, link.s_sync_ready}, 32'h1);
    sym_valid = 1'b0;
    ts_step = 7'h00;
    settle(10);
    check(time_count, tb);
    pwr_req = 1'b0;
    wait_for(resync_seen, 1'b1, 100);
    wait_for(off_ok, 1'b0, 20);
    settle(20);
  endtask
  // gate the clock, offer steps, then ask for power while gated
  task automatic t_gate();
    logic [31:0] tb;
    m_div = 4'h0;
    clk_req = 1'b1;
    wait_for(gated, 1'b1, 20);
    tb = time_count;
    ts_step = 7'h05;
    settle(20);
    ts_step = 7'h00;
    settle(4);
    check(time_count, tb);
    pwr_req = 1'b1;
    wait_for(wake, 1'b1, 10);
    clk_req = 1'b0;
    wait_for(off_ok, 1'b1, 600);
    pwr_req = 1'b0;
    wait_for(off_ok, 1'b0, 100);
    settle(60);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    wait_for(resync_seen, 1'b1, 100);
    t_steps(7'h03, 4'h0, 4'h0, 40);
    t_steps(7'h05, 4'h0, 4'hf, 120);
    t_steps(7'h02, 4'h3, 4'h0, 60);
    t_steps(7'h07, 4'h1, 4'h2, 200);
    t_overflow();
    t_sync();
    t_power();
    t_gate();
    tally_and_finish();
  end
endmodule
`default_nettype wire
